// [core/sdram_controller_core.sv]
`timescale 1ns/1ps
`include "sdram_regs.svh"
module sdram_controller_core (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [4:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic SYS_REQ,
    input wire logic SYS_WE,
    input wire logic [26:0] SYS_ADDR,
    input wire logic [3:0] SYS_SEL,
    input wire logic [31:0] SYS_WDATA,
    output logic SYS_ACK,
    output logic [31:0] SYS_RDATA,
    output logic MEM_CKE,
    output logic [1:0] MEM_CHIP_SELECT_N,
    output logic MEM_ROW_STROBE_N,
    output logic MEM_COL_STROBE_N,
    output logic MEM_WRITE_ENABLE_N,
    output logic [14:0] MEM_ADDR_OUT,
    output logic [31:0] MEM_DQ_O,
    input wire logic [31:0] MEM_DQ_I,
    output logic MEM_DQ_OE_N,
    output logic [3:0] MEM_DQM
);
    sdram_pkg::state_type v_r;
    sdram_pkg::state_type v_nxt;
    logic half_bus;
    logic apctl;
    logic [3:0] bl;
    logic [4:0] rp;
    logic [4:0] rcd;
    logic [4:0] rc;
    logic norm;
    logic sreq;
    logic busy;
    logic [1:0] hit;
    logic m;
    logic dsel;
    logic go;
    logic gwr;
    logic fl;
    logic [26:0] tgt;
    logic tcs;
    logic [1:0] tden;
    logic [14:0] trow;
    logic [1:0] cden;
    logic [35:0] bo;
    logic [31:0] rd;
    logic [31:0] wv;

    // Both widths share one table: the 16-bit map is the 32-bit map one bit lower
    function automatic logic [14:0] map_addr(input logic [25:0] a0, input logic w16,
                                             input logic [1:0] d, input logic col, input logic auto_pre);
        logic [26:0] a;
        logic [14:0] mo;
        a = w16 ? {a0, 1'b0} : {1'b0, a0};
        mo = 15'h0000;
        if (col) begin
            mo[7:0] = a[9:2];
            mo[10] = auto_pre;
            case (d)
                2'h0: mo[8] = a[22];
                2'h1: mo[8] = a[24];
                2'h2: mo[9:8] = a[25:24];
                default: mo[9:8] = a[26:25];
            endcase
        end else begin
            mo[10:0] = a[20:10];
            if (d != 2'h0) mo[11] = a[23];
            if (d == 2'h3) mo[12] = a[24];
        end
        mo[13] = a[21];
        if (d != 2'h0) mo[14] = a[22];
        return mo;
    endfunction: map_addr

    function automatic logic [31:0] bmask(input logic [31:0] o, input logic [31:0] d, input logic [3:0] se);
        logic [31:0] n;
        n = o;
        for (int i = 0; i < 4; i++) begin
            if (se[i]) n[i*8 +: 8] = d[i*8 +: 8];
        end
        return n;
    endfunction: bmask

    // Returns {dqm, dq}; unwritten bytes stay masked so merging needs no read
    function automatic logic [35:0] beat_out(input logic [127:0] dat, input logic [15:0] be,
                                             input logic w16, input logic [3:0] b);
        logic [35:0] o;
        if (w16) begin
            o = {2'b11, ~be[b*2 +: 2], 16'h0000, dat[b*16 +: 16]};
        end else begin
            o = {~be[b[1:0]*4 +: 4], dat[b[1:0]*32 +: 32]};
        end
        return o;
    endfunction: beat_out

    generate
        for (genvar g = 0; g < 2; g++) begin : g_hit
            assign hit[g] = v_r.wb.vld[g] && v_r.wb.qa[g] == SYS_ADDR[26:4];
        end
    endgenerate

    always_comb begin
        v_nxt = v_r;
        v_nxt.p.cmd = `C_NOP;
        v_nxt.p.cs_n = 2'b11;
        v_nxt.p.dq_oe_n = 1'b1;
        v_nxt.p.dqm = 4'h0;
        v_nxt.wb_ack = 1'b0;
        v_nxt.sys_ack = 1'b0;
        if (v_r.wt != 5'h00) v_nxt.wt = v_r.wt - 5'h01;
        half_bus = v_r.cfg[`CFG_EXT_WIDTH_SEL];
        apctl = v_r.cfg[`CFG_AUTO_PRECHARGE_CTL];
        bl = half_bus ? `BL16 : `BL32;
        rp = {3'h0, v_r.cfg[`CFG_RP]} + 5'h01;
        rcd = {3'h0, v_r.cfg[`CFG_RCD]} + 5'h01;
        rc = {1'b0, v_r.cfg[`CFG_RC]} + 5'h01;
        norm = v_r.init == `INIT_NORM && v_r.selfref_ack && !v_r.srreq;
        sreq = SYS_REQ && !v_r.sys_ack && norm;
        busy = v_r.st != sdram_pkg::S_IDLE || (|v_r.wb.pend) || v_r.pall_req || v_r.mrs_req;
        m = v_r.mi;
        dsel = v_r.wb.pend[!v_r.mi] ? !v_r.mi : v_r.mi;
        tgt = (|v_r.wb.pend) ? {v_r.wb.qa[dsel], 4'h0} : SYS_ADDR;
        tcs = tgt[`BANK_BIT];
        tden = tcs ? v_r.cfg[`CFG_BANK1_DENSITY_SEL] : v_r.cfg[`CFG_BANK0_DENSITY_SEL];
        trow = map_addr(tgt[25:0], half_bus, tden, 1'b0, 1'b0);
        cden = v_r.cur[`BANK_BIT] ? v_r.cfg[`CFG_BANK1_DENSITY_SEL] : v_r.cfg[`CFG_BANK0_DENSITY_SEL];
        bo = beat_out(v_r.wb.dat[v_r.di], v_r.wb.be[v_r.di], half_bus, v_r.beat);
        go = 1'b0;
        gwr = 1'b0;
        fl = 1'b0;
        rd = 32'h0000_0000;
        wv = 32'h0000_0000;

        // Flush triggers on the merging entry
        if (v_r.wb.vld[m] && !v_r.wb.pend[m]) begin
            if (!v_r.wben || v_r.wbtcnt == 16'h0000) begin
                fl = 1'b1;
            end else if (sreq && !SYS_WE && hit[m]) begin
                fl = 1'b1;
            end else if (sreq && SYS_WE && !hit[m]) begin
                fl = 1'b1;
            end else begin
                v_nxt.wbtcnt = v_r.wbtcnt - 16'h0001;
            end
            if (fl) v_nxt.wb.pend[m] = 1'b1;
        end
        // New writes move to the free entry while the flushed one drains
        if (v_r.wb.pend[m] && !v_r.wb.vld[!m]) v_nxt.mi = !m;
        if (sreq && SYS_WE && !fl && !v_r.wb.pend[m]) begin
            if (!v_r.wb.vld[m]) begin
                v_nxt.wb.vld[m] = 1'b1;
                v_nxt.wb.qa[m] = SYS_ADDR[26:4];
                v_nxt.wb.be[m] = 16'h0000;
                v_nxt.wb.dat[m] = 128'h0;
            end
            for (int i = 0; i < 4; i++) begin
                if (SYS_SEL[i]) v_nxt.wb.dat[m][SYS_ADDR[3:2]*32 + i*8 +: 8] = SYS_WDATA[i*8 +: 8];
            end
            v_nxt.wb.be[m][SYS_ADDR[3:2]*4 +: 4] = v_nxt.wb.be[m][SYS_ADDR[3:2]*4 +: 4] | SYS_SEL;
            v_nxt.wbtcnt = v_r.wbto;
            v_nxt.sys_ack = 1'b1;
        end

        case (v_r.st)
            sdram_pkg::S_IDLE: begin
                if (v_r.srreq && v_r.selfref_ack) begin
                    v_nxt.p.cmd = `C_PRE;
                    v_nxt.p.cs_n = 2'b00;
                    v_nxt.p.addr = `A10_ALL;
                    v_nxt.open_vld = 1'b0;
                    v_nxt.selfref_ack = 1'b0;
                    v_nxt.wt = rp;
                    v_nxt.st = sdram_pkg::S_SRE;
                end else if (v_r.pall_req) begin
                    v_nxt.p.cmd = `C_PRE;
                    v_nxt.p.cs_n = 2'b00;
                    v_nxt.p.addr = `A10_ALL;
                    v_nxt.open_vld = 1'b0;
                    v_nxt.pall_req = 1'b0;
                    v_nxt.wt = rp;
                    v_nxt.st = sdram_pkg::S_RECOV;
                end else if (v_r.mrs_req) begin
                    v_nxt.p.cmd = `C_MRS;
                    v_nxt.p.cs_n = 2'b00;
                    v_nxt.p.addr = {8'h00, 1'b0, v_r.cfg[`CFG_CL], 1'b0, half_bus ? `MRS_BL16 : `MRS_BL32};
                    v_nxt.mrs_req = 1'b0;
                    v_nxt.wt = rc;
                    v_nxt.st = sdram_pkg::S_RECOV;
                end else if (v_r.ref_req) begin
                    v_nxt.p.cs_n = 2'b00;
                    if (v_r.open_vld) begin
                        // Open rows must close before a refresh
                        v_nxt.p.cmd = `C_PRE;
                        v_nxt.p.addr = `A10_ALL;
                        v_nxt.open_vld = 1'b0;
                        v_nxt.wt = rp;
                    end else begin
                        v_nxt.p.cmd = `C_REF;
                        v_nxt.ref_req = 1'b0;
                        v_nxt.wt = rc;
                    end
                    v_nxt.st = sdram_pkg::S_RECOV;
                end else if (norm && (|v_r.wb.pend)) begin
                    go = 1'b1;
                    gwr = 1'b1;
                end else if (sreq && !SYS_WE && !(|hit)) begin
                    go = 1'b1;
                end
                if (go) begin
                    v_nxt.cur = tgt;
                    v_nxt.op_wr = gwr;
                    v_nxt.di = dsel;
                    if (v_r.open_vld && v_r.open_cs == tcs && v_r.open_row == trow) begin
                        v_nxt.st = sdram_pkg::S_CMD;
                    end else if (v_r.open_vld) begin
                        v_nxt.p.cmd = `C_PRE;
                        v_nxt.p.cs_n = v_r.open_cs ? 2'b01 : 2'b10;
                        v_nxt.p.addr = {v_r.open_row[14:13], 13'h0000};
                        v_nxt.open_vld = 1'b0;
                        v_nxt.wt = rp;
                        v_nxt.st = sdram_pkg::S_RECOV;
                    end else begin
                        v_nxt.p.cmd = `C_ACT;
                        v_nxt.p.cs_n = tcs ? 2'b01 : 2'b10;
                        v_nxt.p.addr = trow;
                        v_nxt.open_vld = apctl;
                        v_nxt.open_cs = tcs;
                        v_nxt.open_row = trow;
                        v_nxt.wt = rcd;
                        v_nxt.st = sdram_pkg::S_RCD;
                    end
                end
            end
            sdram_pkg::S_RCD: begin
                if (v_r.wt <= 5'h01) v_nxt.st = sdram_pkg::S_CMD;
            end
            sdram_pkg::S_CMD: begin
                v_nxt.p.cs_n = v_r.cur[`BANK_BIT] ? 2'b01 : 2'b10;
                v_nxt.p.addr = map_addr(v_r.cur[25:0], half_bus, cden, 1'b1, !apctl);
                v_nxt.st = sdram_pkg::S_BURST;
                if (v_r.op_wr) begin
                    v_nxt.p.cmd = `C_WR;
                    v_nxt.p.dq_oe_n = 1'b0;
                    {v_nxt.p.dqm, v_nxt.p.dq} = beat_out(v_r.wb.dat[v_r.di], v_r.wb.be[v_r.di], half_bus, 4'h0);
                    v_nxt.beat = 4'h1;
                end else begin
                    v_nxt.p.cmd = `C_RD;
                    v_nxt.beat = 4'h0;
                    v_nxt.wt = {3'h0, v_r.cfg[`CFG_CL]};
                end
            end
            sdram_pkg::S_BURST: begin
                if (v_r.op_wr) begin
                    v_nxt.p.dq_oe_n = 1'b0;
                    {v_nxt.p.dqm, v_nxt.p.dq} = bo;
                    v_nxt.beat = v_r.beat + 4'h1;
                    if (v_r.beat == bl - 4'h1) begin
                        v_nxt.wb.vld[v_r.di] = 1'b0;
                        v_nxt.wb.pend[v_r.di] = 1'b0;
                        v_nxt.wt = rp;
                        v_nxt.st = sdram_pkg::S_RECOV;
                    end
                end else if (v_r.wt == 5'h00) begin
                    // Whole burst is waited out so the bus is free for the next command
                    if (v_r.beat == 4'h0) begin
                        v_nxt.rdata = half_bus ? {16'h0000, MEM_DQ_I[15:0]} : MEM_DQ_I;
                    end else if (v_r.beat == 4'h1 && half_bus) begin
                        v_nxt.rdata[31:16] = MEM_DQ_I[15:0];
                    end
                    v_nxt.beat = v_r.beat + 4'h1;
                    if (v_r.beat == bl - 4'h1) begin
                        v_nxt.sys_ack = 1'b1;
                        v_nxt.wt = rp;
                        v_nxt.st = sdram_pkg::S_RECOV;
                    end
                end
            end
            sdram_pkg::S_RECOV: begin
                if (v_r.wt <= 5'h01) v_nxt.st = sdram_pkg::S_IDLE;
            end
            sdram_pkg::S_SRE: begin
                if (v_r.wt <= 5'h01) begin
                    v_nxt.p.cmd = `C_REF;
                    v_nxt.p.cs_n = 2'b00;
                    v_nxt.p.cke = 1'b0;
                    v_nxt.selfref_ack = 1'b1;
                    v_nxt.st = sdram_pkg::S_SR;
                end
            end
            sdram_pkg::S_SR: begin
                if (!v_r.srreq) begin
                    v_nxt.p.cke = 1'b1;
                    v_nxt.selfref_ack = 1'b0;
                    v_nxt.wt = rc;
                    v_nxt.st = sdram_pkg::S_SRX;
                end
            end
            sdram_pkg::S_SRX: begin
                if (v_r.wt <= 5'h01) begin
                    v_nxt.selfref_ack = 1'b1;
                    v_nxt.st = sdram_pkg::S_IDLE;
                end
            end
            default: begin
                v_nxt.st = sdram_pkg::S_IDLE;
            end
        endcase

        // Timer runs after the engine so a new expiry is never lost to a clear
        if (v_r.refcnt <= 16'h0001) begin
            v_nxt.refcnt = v_r.refv;
            v_nxt.ref_req = 1'b1;
        end else begin
            v_nxt.refcnt = v_r.refcnt - 16'h0001;
        end

        if (WB_CYC_I && WB_STB_I && !v_r.wb_ack) begin
            v_nxt.wb_ack = 1'b1;
            case (WB_ADR_I)
                `CFG_OFS: rd = {12'h000, v_r.cfg};
                `CMD_OFS: rd = {28'h0000000, busy, v_r.wben, v_r.init};
                `REF_OFS: rd = {16'h0000, v_r.refv};
                `WBTO_OFS: rd = {16'h0000, v_r.wbto};
                `PCG_OFS: rd = {30'h00000000, v_r.selfref_ack, v_r.srreq};
                default: rd = 32'h0000_0000;
            endcase
            v_nxt.wb_dat = rd;
            wv = bmask(rd, WB_DAT_I, WB_SEL_I);
            if (WB_WE_I) begin
                case (WB_ADR_I)
                    `CFG_OFS: v_nxt.cfg = wv[19:0];
                    `CMD_OFS: begin
                        v_nxt.init = wv[`CMD_INIT];
                        v_nxt.wben = wv[`CMD_WBEN];
                        if (WB_SEL_I[0] && wv[`CMD_INIT] == `INIT_PALL) v_nxt.pall_req = 1'b1;
                        if (WB_SEL_I[0] && wv[`CMD_INIT] == `INIT_MRS) v_nxt.mrs_req = 1'b1;
                    end
                    `REF_OFS: begin
                        v_nxt.refv = wv[15:0];
                        v_nxt.refcnt = wv[15:0];
                    end
                    `WBTO_OFS: v_nxt.wbto = wv[15:0];
                    `PCG_OFS: v_nxt.srreq = wv[`PCG_SRREQ];
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            v_r <= '0;
            v_r.cfg <= `CFG_RST;
            v_r.refv <= `REF_RST;
            v_r.refcnt <= `REF_RST;
            v_r.selfref_ack <= 1'b1;
            v_r.st <= sdram_pkg::S_IDLE;
            v_r.p.cke <= 1'b1;
            v_r.p.cs_n <= 2'b11;
            v_r.p.cmd <= `C_NOP;
            v_r.p.dq_oe_n <= 1'b1;
        end else begin
            v_r <= v_nxt;
        end
    end

    assign WB_DAT_O = v_r.wb_dat;
    assign WB_ACK_O = v_r.wb_ack;
    assign SYS_ACK = v_r.sys_ack;
    assign SYS_RDATA = v_r.rdata;
    assign MEM_CKE = v_r.p.cke;
    assign MEM_CHIP_SELECT_N = v_r.p.cs_n;
    assign MEM_ROW_STROBE_N = v_r.p.cmd[2];
    assign MEM_COL_STROBE_N = v_r.p.cmd[1];
    assign MEM_WRITE_ENABLE_N = v_r.p.cmd[0];
    assign MEM_ADDR_OUT = v_r.p.addr;
    assign MEM_DQ_O = v_r.p.dq;
    assign MEM_DQ_OE_N = v_r.p.dq_oe_n;
    assign MEM_DQM = v_r.p.dqm;
endmodule: sdram_controller_core

// [core/sdram_regs.svh]
`ifndef SDRAM_REGS_SVH
`define SDRAM_REGS_SVH
// Notes on behaviour
// - 32-bit bus row: lines 10..0 from bits 20..10, 13/14/11/12 by density.
// - 16-bit bus row: lines 10..0 from bits 19..9, upper lines shifted one down.
// - 16-bit column: lines 7..0 from bits 8..1; lines 13/14 select the leaf.
// - Line 10 requests auto precharge on column; on precharge selects all banks.
// - Encode MRS, auto refresh, self refresh (clock enable low) and activate.
// - Encode read, write, precharge and no-operation; only a command subset is used.
// - Both 32-bit and 16-bit data buses; width field selects the address mapping.
// - Two quad-word write buffers; one merges while the other drains.
// - Writes of any width within one quad word merge into one burst.
// - A write outside the merging quad word flushes the merging buffer.
// - A read hitting a buffered quad word waits until it is written out.
// - Merging buffer also flushes on timeout reaching zero or buffering disabled.
// - Expiry of the periodic refresh timer requests an auto refresh; expiries while one is pending merge.
// - Self-refresh request bit set enters self refresh; cleared leaves it.
// - Self-refresh acknowledge is low during entry or exit, high when done.
// - Writing 01 to the init field issues a precharge-all command.
// - Writing 10 to the init field issues MRS; 00 enters normal mode.
// - Auto refreshes are spaced by the refresh register count of clocks.
// - Width bit 0 clear selects 32-bit bus, set selects 16-bit bus.
// - Auto-precharge bit 1 clear uses auto precharge, set leaves rows open.
// - Each bank's 2-bit density field chooses 16M, 64M, 128M or 256M mapping.
`define CFG_OFS 5'h00
`define CMD_OFS 5'h04
`define REF_OFS 5'h08
`define WBTO_OFS 5'h0C
`define PCG_OFS 5'h10
`define CFG_RST 20'h99F0C
`define REF_RST 16'h0020
`define CFG_EXT_WIDTH_SEL 0
`define CFG_AUTO_PRECHARGE_CTL 1
`define CFG_CL 3:2
`define CFG_BANK1_DENSITY_SEL 5:4
`define CFG_BANK0_DENSITY_SEL 7:6
`define CFG_RP 9:8
`define CFG_RCD 11:10
`define CFG_RC 15:12
`define CMD_INIT 1:0
`define CMD_WBEN 2
`define CMD_BUSY 3
`define PCG_SRREQ 0
`define PCG_SELFREF_ACK 1
`define INIT_NORM 2'h0
`define INIT_PALL 2'h1
`define INIT_MRS 2'h2
`define MRS_BL32 3'h2
`define MRS_BL16 3'h3
`define BL32 4'h4
`define BL16 4'h8
`define BANK_BIT 26
`define C_MRS 3'h0
`define C_REF 3'h1
`define C_PRE 3'h2
`define C_ACT 3'h3
`define C_WR 3'h4
`define C_RD 3'h5
`define C_NOP 3'h7
`define A10_ALL 15'h0400
`endif

// [core/sdram_pkg.sv]
package sdram_pkg;
    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_ACT = 4'h1, S_RCD = 4'h3, S_CMD = 4'h2,
        S_BURST = 4'h6, S_RECOV = 4'h7, S_SRE = 4'h5, S_SR = 4'h4,
        S_SRX = 4'hC
    } st_type;
    typedef struct packed {
        logic cke;
        logic [1:0] cs_n;
        logic [2:0] cmd;
        logic [14:0] addr;
        logic [31:0] dq;
        logic dq_oe_n;
        logic [3:0] dqm;
    } pins_type;
    typedef struct packed {
        logic [1:0] vld;
        logic [1:0] pend;
        logic [1:0][22:0] qa;
        logic [1:0][15:0] be;
        logic [1:0][127:0] dat;
    } wbuf_type;
    typedef struct packed {
        logic [19:0] cfg;
        logic [1:0] init;
        logic wben;
        logic [15:0] refv;
        logic [15:0] wbto;
        logic srreq;
        logic selfref_ack;
        logic wb_ack;
        logic [31:0] wb_dat;
        logic pall_req;
        logic mrs_req;
        logic ref_req;
        logic [15:0] refcnt;
        logic [15:0] wbtcnt;
        st_type st;
        logic [4:0] wt;
        logic [3:0] beat;
        logic mi;
        logic di;
        logic op_wr;
        logic [26:0] cur;
        logic open_vld;
        logic open_cs;
        logic [14:0] open_row;
        logic sys_ack;
        logic [31:0] rdata;
        wbuf_type wb;
        pins_type p;
    } state_type;
endpackage: sdram_pkg

// [verif/sdram_core_assertions.sv]
`timescale 1ns/1ps
module sdram_core_assertions (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic SYS_ACK,
    input wire logic MEM_CKE,
    input wire logic [1:0] MEM_CHIP_SELECT_N,
    input wire logic MEM_ROW_STROBE_N,
    input wire logic MEM_COL_STROBE_N,
    input wire logic MEM_WRITE_ENABLE_N,
    input wire logic [14:0] MEM_ADDR_OUT,
    input wire logic MEM_DQ_OE_N
);
    logic [2:0] cmd;
    logic sel;
    assign cmd = {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N};
    assign sel = MEM_CHIP_SELECT_N != 2'b11;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    property p_wb_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("ack late");
    property p_wb_one; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_wb_one: assert property (p_wb_one) else $error("ack long");
    property p_sys_one; SYS_ACK |=> !SYS_ACK; endproperty
    a_sys_one: assert property (p_sys_one) else $error("sys ack long");
    property p_pall; sel && cmd == 3'b010 && MEM_CHIP_SELECT_N == 2'b00 |-> MEM_ADDR_OUT[10]; endproperty
    a_pall: assert property (p_pall) else $error("all-bank line low");
    property p_sref; $fell(MEM_CKE) |-> cmd == 3'b001 && MEM_CHIP_SELECT_N == 2'b00; endproperty
    a_sref: assert property (p_sref) else $error("bad self refresh");
    property p_nop; !sel |-> cmd == 3'b111; endproperty
    a_nop: assert property (p_nop) else $error("bad idle");
    property p_dq; $fell(MEM_DQ_OE_N) |-> sel && cmd == 3'b100; endproperty
    a_dq: assert property (p_dq) else $error("drive without write");
    property p_ref; sel && MEM_CKE && cmd == 3'b001 |-> MEM_CHIP_SELECT_N == 2'b00; endproperty
    a_ref: assert property (p_ref) else $error("refresh not both");
endmodule: sdram_core_assertions
bind sdram_controller_core sdram_core_assertions i_chk (.*);

// [verif/sdram_mem_model.sv]
`timescale 1ns/1ps
module sdram_mem_model #(parameter int CL = 3, parameter int BL = 4) (
    input wire logic CLK,
    input wire logic MEM_CKE,
    input wire logic [1:0] MEM_CHIP_SELECT_N,
    input wire logic MEM_ROW_STROBE_N,
    input wire logic MEM_COL_STROBE_N,
    input wire logic MEM_WRITE_ENABLE_N,
    input wire logic [14:0] MEM_ADDR_OUT,
    input wire logic [31:0] MEM_DQ_O,
    input wire logic MEM_DQ_OE_N,
    input wire logic [3:0] MEM_DQM,
    output logic [31:0] MEM_DQ_I,
    output logic [14:0] act_a,
    output logic [14:0] col_a,
    output int cnt [6]
);
    logic [31:0] mem [4] = '{default: 0};
    logic [31:0] last = 0;
    logic [2:0] cmd;
    logic [1:0] rc = 0, wp = 0, wi;
    logic go;
    int t = 0, cyc = 0, ref_t = 0;
    assign cmd = {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N};
    assign go = MEM_CHIP_SELECT_N != 2'b11;
    assign wi = (go && cmd == 3'b100) ? MEM_ADDR_OUT[1:0] : wp;
    // Idle bus inverts the last beat so a stale sample cannot pass
    assign MEM_DQ_I = (t >= CL && t < CL + BL) ? mem[2'(rc + t - CL)] : ~last;
    initial cnt = '{default: 0};
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        t <= (t > 0 && t < CL + BL) ? t + 1 : 0;
        if (t >= CL && t < CL + BL) last <= MEM_DQ_I;
        if (!MEM_DQ_OE_N) begin
            for (int b = 0; b < 4; b++) begin
                if (!MEM_DQM[b]) mem[wi][8 * b +: 8] <= MEM_DQ_O[8 * b +: 8];
            end
            wp <= wi + 2'd1;
        end
        if (go) begin
            case (cmd)
                3'b000: cnt[2] <= cnt[2] + 1;
                3'b001: begin
                    cnt[MEM_CKE ? 0 : 3] <= cnt[MEM_CKE ? 0 : 3] + 1;
                    cnt[5] <= MEM_CKE ? cyc - ref_t : cnt[5];
                    ref_t <= cyc;
                end
                3'b010: cnt[1] <= cnt[1] + (MEM_ADDR_OUT[10] ? 1 : 0);
                3'b011: act_a <= MEM_ADDR_OUT;
                3'b100: begin
                    col_a <= MEM_ADDR_OUT;
                    cnt[4] <= cnt[4] + 1;
                end
                3'b101: begin
                    col_a <= MEM_ADDR_OUT;
                    rc <= MEM_ADDR_OUT[1:0];
                    t <= 1;
                end
                default: ;
            endcase
        end
    end
endmodule: sdram_mem_model

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic CLK = 0, RESETN = 0, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, SYS_REQ = 0, SYS_WE = 0;
    logic [4:0] WB_ADR_I = 0;
    logic [3:0] WB_SEL_I = 0, SYS_SEL = 0, MEM_DQM;
    logic [31:0] WB_DAT_I = 0, SYS_WDATA = 0, WB_DAT_O, SYS_RDATA, MEM_DQ_O, MEM_DQ_I, rd;
    logic [26:0] SYS_ADDR = 0;
    logic WB_ACK_O, SYS_ACK, MEM_CKE, MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N, MEM_DQ_OE_N;
    logic [1:0] MEM_CHIP_SELECT_N;
    logic [14:0] MEM_ADDR_OUT, act_a, col_a;
    int cnt [6];
    int n_fail = 0, check_count = 0, p;
    localparam logic [26:0] qa = 27'h15AB5A0;
    localparam logic [26:0] qc = 27'h0A5C6E0;
    always #2.5 CLK = ~CLK;
    sdram_controller_core i_dut (.*);
    sdram_mem_model i_mem (.*);
    task automatic fail(input string m);
        n_fail++;
        $display("mismatch at %0t: %s", $time, m);
    endtask: fail
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) fail(m);
    endtask: chk
    task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
        WB_CYC_I <= 1;
        WB_STB_I <= 1;
        WB_WE_I <= we;
        WB_ADR_I <= a;
        WB_SEL_I <= 4'hF;
        WB_DAT_I <= d;
        do @(posedge CLK); while (WB_ACK_O !== 1'b1);
        rd = WB_DAT_O;
        WB_CYC_I <= 0;
        WB_STB_I <= 0;
        @(posedge CLK);
    endtask: wb
    task automatic sys(input logic we, input logic [26:0] a, input logic [3:0] s, input logic [31:0] d);
        SYS_REQ <= 1;
        SYS_WE <= we;
        SYS_ADDR <= a;
        SYS_SEL <= s;
        SYS_WDATA <= d;
        do @(posedge CLK); while (SYS_ACK !== 1'b1);
        rd = SYS_RDATA;
        SYS_REQ <= 0;
        @(posedge CLK);
    endtask: sys
    task automatic idle;
        do wb(0, 5'h04, 0); while (rd[3] !== 1'b0);
    endtask: idle
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask: finish_test
    initial begin
        // About a hundred times the expected run
        #300000;
        fail("watchdog");
        finish_test;
    end
    initial begin
        logic [31:0] rv [6] = '{32'h99F0C, 0, 32'h20, 0, 32'h2, 0};
        repeat (12) @(posedge CLK);
        RESETN <= 1;
        @(posedge CLK);
        wb(1, 5'h14, 32'hFFFF);
        for (int i = 0; i < 6; i++) begin
            wb(0, 5'(4 * i), 0);
            chk(rd, rv[i], "reset value");
        end
        p = cnt[1];
        wb(1, 5'h04, 1);
        idle;
        chk(cnt[1], p + 1, "precharge-all");
        p = cnt[0];
        wb(1, 5'h08, 32'hF);
        repeat (120) @(posedge CLK);
        chk(cnt[5], 15, "refresh gap");
        chk(cnt[0] >= p + 7, 1, "refresh count");
        wb(1, 5'h08, 32'h400);
        idle;
        wb(1, 5'h00, 32'h99FCC);
        p = cnt[2];
        wb(1, 5'h04, 2);
        idle;
        chk(cnt[2], p + 1, "mode set");
        wb(1, 5'h04, 0);
        wb(1, 5'h0C, 32'h40);
        wb(1, 5'h04, 4);
        p = cnt[4];
        sys(1, qa, 4'hF, 32'h11112222);
        sys(1, qa + 8, 4'h3, 32'hAAAA5678);
        sys(0, qa + 8, 4'hF, 0);
        chk(cnt[4], p + 1, "merged burst");
        chk(rd, 32'h5678, "read hit data");
        chk(act_a, {qa[22:21], qa[24:23], qa[20:10]}, "row 32");
        chk(col_a & 15'h64FC, {qa[22:21], 2'b0, 1'b1, 2'b0, qa[9:4], 2'b0}, "col 32");
        p = cnt[4];
        sys(1, qa + 16, 4'hF, 1);
        sys(1, qa + 32, 4'hF, 2);
        repeat (30) @(posedge CLK);
        chk(cnt[4], p + 1, "miss flush");
        repeat (100) @(posedge CLK);
        chk(cnt[4], p + 2, "timeout flush");
        wb(1, 5'h04, 0);
        sys(1, qa + 48, 4'hF, 3);
        repeat (30) @(posedge CLK);
        chk(cnt[4], p + 3, "unbuffered flush");
        idle;
        wb(1, 5'h00, 32'h99F4F);
        sys(0, qc, 4'hF, 0);
        chk(rd, 32'h3, "read 16");
        chk(act_a & 15'h6FFF, {qc[21:20], 1'b0, qc[22], qc[19:9]}, "row 16");
        chk(col_a & 15'h64FF, {qc[21:20], 5'h0, qc[8:1]}, "col 16");
        p = cnt[3];
        wb(1, 5'h10, 1);
        wb(0, 5'h10, 0);
        chk(rd[1:0], 2'b01, "ack in entry");
        do wb(0, 5'h10, 0); while (rd[1] !== 1'b1);
        chk(MEM_CKE, 0, "cke in self refresh");
        chk(cnt[3], p + 1, "self refresh cmd");
        wb(1, 5'h10, 0);
        do wb(0, 5'h10, 0); while (rd[1] !== 1'b1);
        chk(MEM_CKE, 1, "cke after exit");
        sys(0, qc, 4'hF, 0);
        chk(rd, 32'h3, "read after exit");
        finish_test;
    end
endmodule: tb_top
